// File: design/ica_allocator.v
// I/O chain address allocator: map walk, input update, image and analog access
`timescale 1ns/100ps
`include "ica_regs.vh"

// How it works
// - Base unit points take input bytes 0-1 and output bytes 0-1 whatever is chained.
// - Each module's bases come from its type and position, continuing the same-type pointer.
// - Digital in, digital out, analog in and analog out each keep a pointer of their own.
// - A digital module takes whole bytes, its point count rounded up to eight.
// - The next module starts at the next free byte, never in a previous module's spare bits.
// - Every bit of the output image, spare or not, is plain read-write program storage.
// - Each input update writes field data ANDed with a mask, so spare input bits read zero.
// - Analog inputs and outputs are each counted in even numbers of points.
// - Analog pad points are not given onward and any access to them is a miss.
// - Analog accesses are forwarded straight to the module, with no image kept.
// - Analog points sit at even word addresses, two per point.
// - Image bytes above the last installed byte are left to the program as flag storage.
module ica_allocator (
  // Clock, reset, enable
  input wire core_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // Chain descriptors
  output wire [`ICA_IDX_W-1:0] desc_idx_o,
  input wire desc_present_i,
  input wire [`ICA_PTS_W-1:0] desc_din_pts_i,
  input wire [`ICA_PTS_W-1:0] desc_dout_pts_i,
  input wire [`ICA_PTS_W-1:0] desc_ain_pts_i,
  input wire [`ICA_PTS_W-1:0] desc_aout_pts_i,
  // Map status and query
  output reg map_valid_o,
  output reg cfg_err_o,
  output reg [`ICA_PTR_W-1:0] in_bytes_o,
  output reg [`ICA_PTR_W-1:0] out_bytes_o,
  input wire [`ICA_IDX_W-1:0] qry_idx_i,
  output reg qry_valid_o,
  output reg [`ICA_PTR_W-1:0] qry_din_base_o,
  output reg [`ICA_PTR_W-1:0] qry_dout_base_o,
  output reg [7:0] qry_ain_word_o,
  output reg [7:0] qry_aout_word_o,
  // Input update cycle
  input wire upd_start_i,
  output wire upd_busy_o,
  output reg upd_done_o,
  output reg [`ICA_IMG_AW-1:0] fld_addr_o,
  input wire [7:0] fld_data_i,
  // Program access to the digital image
  input wire prog_req_i,
  input wire prog_we_i,
  input wire prog_out_i,
  input wire [`ICA_IMG_AW-1:0] prog_addr_i,
  input wire [7:0] prog_wdata_i,
  output wire prog_ready_o,
  output reg prog_rvalid_o,
  output wire [7:0] prog_rdata_o,
  // Program analog access
  input wire ana_req_i,
  input wire ana_we_i,
  input wire ana_out_i,
  input wire [7:0] ana_addr_i,
  input wire [15:0] ana_wdata_i,
  output wire ana_ready_o,
  output reg ana_miss_o,
  output reg ana_rvalid_o,
  output reg [15:0] ana_rdata_o,
  // Analog module side
  output reg mod_req_o,
  output reg mod_we_o,
  output reg mod_out_o,
  output reg [`ICA_IDX_W-1:0] mod_idx_o,
  output reg [`ICA_PTS_W-1:0] mod_chan_o,
  output reg [15:0] mod_wdata_o,
  input wire mod_ack_i,
  input wire [15:0] mod_rdata_i
);

  // ----------------------------------------
  // States and helpers
  // ----------------------------------------
  localparam ST_MASK = 4'b0001;
  localparam ST_LOAD = 4'b0010;
  localparam ST_READY = 4'b0100;
  localparam ST_UPD = 4'b1000;
  // Base unit output bytes, fixed whatever is chained
  localparam [`ICA_PTR_W-1:0] LOCAL_OUT_BYTES = ({1'b0, `ICA_LOCAL_OUT_PTS} + 6'd7) >> 3;

  // Whole bytes needed for a point count
  function [`ICA_PTR_W-1:0] bytes_of;
    input [`ICA_PTS_W-1:0] pts;
    begin
      bytes_of = ({1'b0, pts} + 6'd7) >> 3;
    end
  endfunction

  // Point count rounded up to an even number
  function [`ICA_APTR_W-1:0] even_of;
    input [`ICA_PTS_W-1:0] pts;
    begin
      even_of = {1'b0, ({1'b0, pts} + 6'd1) & 6'h3E};
    end
  endfunction

  reg [3:0] state;
  reg [`ICA_IDX_W-1:0] idx;
  reg walk_end;
  reg [`ICA_PTS_W-1:0] in_left;
  reg [`ICA_PTR_W-1:0] in_ptr;
  reg [`ICA_PTR_W-1:0] out_ptr;
  reg [`ICA_APTR_W-1:0] ain_ptr;
  reg [`ICA_APTR_W-1:0] aout_ptr;
  reg [`ICA_PTR_W-1:0] upd_ptr;
  reg upd_wr;
  reg ana_busy;
  reg [`ICA_MAX_MODS-1:0] mod_valid;
  reg [`ICA_PTR_W-1:0] din_base [0:`ICA_MAX_MODS-1];
  reg [`ICA_PTR_W-1:0] dout_base [0:`ICA_MAX_MODS-1];
  reg [`ICA_APTR_W-1:0] ain_base [0:`ICA_MAX_MODS-1];
  reg [`ICA_APTR_W-1:0] aout_base [0:`ICA_MAX_MODS-1];
  reg [`ICA_PTS_W-1:0] ain_cnt [0:`ICA_MAX_MODS-1];
  reg [`ICA_PTS_W-1:0] aout_cnt [0:`ICA_MAX_MODS-1];

  wire [`ICA_PTR_W-1:0] new_in_end = in_ptr + bytes_of(desc_din_pts_i);
  wire [`ICA_PTR_W-1:0] new_out_end = out_ptr + bytes_of(desc_dout_pts_i);
  wire [7:0] mask_rdata;
  wire [7:0] img_rdata;
  wire an_hit;
  wire [`ICA_IDX_W-1:0] an_idx;
  wire [`ICA_PTS_W-1:0] an_chan;

  assign desc_idx_o = idx;
  assign upd_busy_o = (state == ST_UPD);
  assign prog_ready_o = (state == ST_READY);
  assign ana_ready_o = map_valid_o && !ana_busy;
  assign prog_rdata_o = img_rdata;

  // ----------------------------------------
  // Input mask and image memories
  // ----------------------------------------
  // Mask byte for the next input byte of the walk
  reg [7:0] mask_wdata;
  reg [`ICA_PTS_W-1:0] in_take;
  always @* begin
    mask_wdata = `ICA_MASK_FULL;
    in_take = {1'b0, `ICA_BYTE_BITS};
    if (in_left < {1'b0, `ICA_BYTE_BITS}) begin
      mask_wdata = ~(`ICA_MASK_FULL << in_left[2:0]);
      in_take = in_left;
    end
  end

  wire mask_we = (state == ST_MASK) && (in_left != {`ICA_PTS_W{1'b0}});

  ica_byte_ram #(.AW(`ICA_IMG_AW), .DW(8)) u_mask_ram (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .we_i(mask_we),
    .waddr_i(in_ptr[`ICA_IMG_AW-1:0]),
    .wdata_i(mask_wdata),
    .raddr_i(upd_ptr[`ICA_IMG_AW-1:0]),
    .rdata_o(mask_rdata)
  );

  // Update writes win; program access is only offered in the ready state
  wire prog_go = prog_req_i && prog_ready_o;
  wire img_we = upd_wr || (prog_go && prog_we_i);
  wire [`ICA_IMG_AW:0] img_waddr = upd_wr ? {1'b0, fld_addr_o} : {prog_out_i, prog_addr_i};
  wire [7:0] img_wdata = upd_wr ? (fld_data_i & mask_rdata) : prog_wdata_i;

  ica_byte_ram #(.AW(`ICA_IMG_AW + 1), .DW(8)) u_img_ram (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .we_i(img_we),
    .waddr_i(img_waddr),
    .wdata_i(img_wdata),
    .raddr_i({prog_out_i, prog_addr_i}),
    .rdata_o(img_rdata)
  );

  // ----------------------------------------
  // Map walk and input update
  // ----------------------------------------
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_MASK;
      idx <= {`ICA_IDX_W{1'b0}};
      walk_end <= 1'b0;
      in_left <= `ICA_LOCAL_IN_PTS;
      in_ptr <= `ICA_PTR_RST;
      out_ptr <= `ICA_PTR_RST + LOCAL_OUT_BYTES;
      ain_ptr <= `ICA_APTR_RST;
      aout_ptr <= `ICA_APTR_RST;
      mod_valid <= {`ICA_MAX_MODS{1'b0}};
      map_valid_o <= 1'b0;
      cfg_err_o <= 1'b0;
      upd_ptr <= `ICA_PTR_RST;
      upd_wr <= 1'b0;
      upd_done_o <= 1'b0;
      fld_addr_o <= {`ICA_IMG_AW{1'b0}};
      prog_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      upd_done_o <= 1'b0;
      prog_rvalid_o <= prog_go && !prog_we_i;
      case (state)
        ST_MASK: begin
          if (mask_we) begin
            in_ptr <= in_ptr + 6'd1;
            in_left <= in_left - in_take;
          end else if (walk_end) begin
            state <= ST_READY;
            map_valid_o <= 1'b1;
          end else begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (!desc_present_i) begin
            state <= ST_READY;
            map_valid_o <= 1'b1;
          end else if (new_in_end > `ICA_IMG_BYTES || new_out_end > `ICA_IMG_BYTES) begin
            state <= ST_READY;
            map_valid_o <= 1'b1;
            cfg_err_o <= 1'b1;
          end else begin
            out_ptr <= new_out_end;
            ain_ptr <= ain_ptr + even_of(desc_ain_pts_i);
            aout_ptr <= aout_ptr + even_of(desc_aout_pts_i);
            in_left <= desc_din_pts_i;
            mod_valid[idx] <= 1'b1;
            idx <= idx + 3'd1;
            walk_end <= (idx == `ICA_MAX_MODS - 1);
            state <= ST_MASK;
          end
        end
        ST_READY: begin
          if (upd_start_i) begin
            state <= ST_UPD;
            upd_ptr <= `ICA_PTR_RST;
          end
        end
        ST_UPD: begin
          // bytes past in_ptr are never overwritten
          if (upd_ptr < in_ptr) begin
            fld_addr_o <= upd_ptr[`ICA_IMG_AW-1:0];
            upd_ptr <= upd_ptr + 6'd1;
            upd_wr <= 1'b1;
          end else begin
            upd_wr <= 1'b0;
            if (!upd_wr) begin
              state <= ST_READY;
              upd_done_o <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_READY;
        end
      endcase
    end
  end

  // Per-module bases captured during the walk
  always @(posedge core_clk_i) begin
    if (ce_i && state == ST_LOAD && desc_present_i) begin
      din_base[idx] <= in_ptr;
      dout_base[idx] <= out_ptr;
      ain_base[idx] <= ain_ptr;
      aout_base[idx] <= aout_ptr;
      ain_cnt[idx] <= desc_ain_pts_i;
      aout_cnt[idx] <= desc_aout_pts_i;
    end
  end

  // Map query and totals, registered
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qry_valid_o <= 1'b0;
      qry_din_base_o <= `ICA_PTR_RST;
      qry_dout_base_o <= `ICA_PTR_RST;
      qry_ain_word_o <= 8'h00;
      qry_aout_word_o <= 8'h00;
      in_bytes_o <= `ICA_PTR_RST;
      out_bytes_o <= `ICA_PTR_RST;
    end else if (ce_i) begin
      in_bytes_o <= in_ptr;
      out_bytes_o <= out_ptr;
      qry_valid_o <= map_valid_o && mod_valid[qry_idx_i];
      qry_din_base_o <= din_base[qry_idx_i];
      qry_dout_base_o <= dout_base[qry_idx_i];
      qry_ain_word_o <= {ain_base[qry_idx_i], 1'b0};
      qry_aout_word_o <= {aout_base[qry_idx_i], 1'b0};
    end
  end

  // ----------------------------------------
  // Analog direct access
  // ----------------------------------------
  wire [`ICA_MAX_MODS*`ICA_APTR_W-1:0] an_base_flat;
  wire [`ICA_MAX_MODS*`ICA_PTS_W-1:0] an_cnt_flat;
  genvar g;
  generate
    for (g = 0; g < `ICA_MAX_MODS; g = g + 1) begin : g_flat
      assign an_base_flat[g*`ICA_APTR_W +: `ICA_APTR_W] = ana_out_i ? aout_base[g] : ain_base[g];
      assign an_cnt_flat[g*`ICA_PTS_W +: `ICA_PTS_W] = ana_out_i ? aout_cnt[g] : ain_cnt[g];
    end
  endgenerate

  ica_an_decode u_an_decode (
    .addr_i(ana_addr_i),
    .valid_i(mod_valid),
    .base_i(an_base_flat),
    .cnt_i(an_cnt_flat),
    .hit_o(an_hit),
    .idx_o(an_idx),
    .chan_o(an_chan)
  );

  // One access in flight; a miss is answered at once
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ana_busy <= 1'b0;
      ana_miss_o <= 1'b0;
      ana_rvalid_o <= 1'b0;
      ana_rdata_o <= 16'h0000;
      mod_req_o <= 1'b0;
      mod_we_o <= 1'b0;
      mod_out_o <= 1'b0;
      mod_idx_o <= {`ICA_IDX_W{1'b0}};
      mod_chan_o <= {`ICA_PTS_W{1'b0}};
      mod_wdata_o <= 16'h0000;
    end else if (ce_i) begin
      ana_miss_o <= 1'b0;
      ana_rvalid_o <= 1'b0;
      if (ana_req_i && ana_ready_o) begin
        if (an_hit) begin
          ana_busy <= 1'b1;
          mod_req_o <= 1'b1;
          mod_we_o <= ana_we_i;
          mod_out_o <= ana_out_i;
          mod_idx_o <= an_idx;
          mod_chan_o <= an_chan;
          mod_wdata_o <= ana_wdata_i;
        end else begin
          ana_miss_o <= 1'b1;
        end
      end else if (mod_req_o && mod_ack_i) begin
        ana_busy <= 1'b0;
        mod_req_o <= 1'b0;
        ana_rvalid_o <= 1'b1;
        ana_rdata_o <= mod_rdata_i;
      end
    end
  end

endmodule

// File: design/ica_regs.vh
// Constants for the I/O chain address allocator
`ifndef ICA_REGS_VH
`define ICA_REGS_VH

// ----------------------------------------
// Chain and image sizes
// ----------------------------------------
`define ICA_MAX_MODS 8
`define ICA_IDX_W 3
`define ICA_PTS_W 5
`define ICA_BYTE_BITS 4'd8
`define ICA_IMG_AW 5
`define ICA_IMG_BYTES 6'd32
`define ICA_PTR_W 6
`define ICA_APTR_W 7

// ----------------------------------------
// Base unit I/O (fixed map, placed first)
// ----------------------------------------
`define ICA_LOCAL_IN_PTS 5'd14
`define ICA_LOCAL_OUT_PTS 5'd10

// ----------------------------------------
// Reset values and the full mask byte
// ----------------------------------------
`define ICA_PTR_RST 6'h00
`define ICA_APTR_RST 7'h00
`define ICA_MASK_FULL 8'hFF

`endif

// File: design/ica_byte_ram.v
// Small simple dual-port memory with registered read data
`timescale 1ns/100ps
module ica_byte_ram #(
  parameter AW = 5,
  parameter DW = 8
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // Write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Array has no reset; only the read register is defined after reset
  always @(posedge core_clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read is registered, so data appear one edge after the address
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= {DW{1'b0}};
    end else if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// File: design/ica_an_decode.v
// Analog word address to chain module and channel decoder
`timescale 1ns/100ps
`include "ica_regs.vh"
module ica_an_decode (
  // Request address
  input wire [7:0] addr_i,
  // Per-module map, module m in slice m
  input wire [`ICA_MAX_MODS-1:0] valid_i,
  input wire [`ICA_MAX_MODS*`ICA_APTR_W-1:0] base_i,
  input wire [`ICA_MAX_MODS*`ICA_PTS_W-1:0] cnt_i,
  // Result
  output reg hit_o,
  output reg [`ICA_IDX_W-1:0] idx_o,
  output reg [`ICA_PTS_W-1:0] chan_o
);

  wire [`ICA_APTR_W-1:0] point = addr_i[7:1];
  wire [`ICA_MAX_MODS-1:0] hit_m;
  wire [`ICA_MAX_MODS*`ICA_APTR_W-1:0] off_m;

  // Only present points hit; rounding pads are lost addresses
  genvar m;
  generate
    for (m = 0; m < `ICA_MAX_MODS; m = m + 1) begin : g_mod
      wire [`ICA_APTR_W-1:0] base = base_i[m*`ICA_APTR_W +: `ICA_APTR_W];
      wire [`ICA_PTS_W-1:0] cnt = cnt_i[m*`ICA_PTS_W +: `ICA_PTS_W];
      assign off_m[m*`ICA_APTR_W +: `ICA_APTR_W] = point - base;
      assign hit_m[m] = valid_i[m] && !addr_i[0] && (point >= base) &&
                        ((point - base) < {2'b00, cnt});
    end
  endgenerate

  // Ranges do not overlap, so the lowest hit is the only hit
  integer k;
  always @* begin
    hit_o = 1'b0;
    idx_o = {`ICA_IDX_W{1'b0}};
    chan_o = {`ICA_PTS_W{1'b0}};
    for (k = `ICA_MAX_MODS - 1; k >= 0; k = k - 1) begin
      if (hit_m[k]) begin
        hit_o = 1'b1;
        idx_o = k[`ICA_IDX_W-1:0];
        chan_o = off_m[k*`ICA_APTR_W +: `ICA_PTS_W];
      end
    end
  end

endmodule

// File: verification/ica_allocator_sva.sv
// Checker for the I/O chain address allocator
`timescale 1ns/100ps
`include "ica_regs.vh"
module ica_allocator_sva (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Map and update
  input wire map_valid_o,
  input wire upd_start_i,
  input wire upd_busy_o,
  input wire upd_done_o,
  // Program image access
  input wire prog_req_i,
  input wire prog_we_i,
  input wire prog_ready_o,
  input wire prog_rvalid_o,
  // Analog access
  input wire ana_req_i,
  input wire ana_ready_o,
  input wire [7:0] ana_addr_i,
  input wire ana_miss_o,
  input wire ana_rvalid_o,
  input wire mod_req_o,
  input wire [`ICA_IDX_W-1:0] mod_idx_o,
  input wire [`ICA_PTS_W-1:0] mod_chan_o,
  input wire mod_ack_i
);
  // All checks run in the core domain and sleep during reset
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  walk_first_a: assert property (!map_valid_o |-> !upd_busy_o && !prog_ready_o)
    else $error("update or access open before the map is built");
  map_hold_a: assert property (map_valid_o |=> map_valid_o)
    else $error("map valid dropped without reset");
  upd_bound_a: assert property (upd_start_i && prog_ready_o |=> ##[0:40] upd_done_o)
    else $error("input update did not finish in time");
  busy_excl_a: assert property (upd_busy_o |-> !prog_ready_o)
    else $error("program access open during input update");
  prog_read_a: assert property (prog_req_i && prog_ready_o && !prog_we_i |=> prog_rvalid_o)
    else $error("image read gave no data next cycle");
  rvalid_cause_a: assert property (prog_rvalid_o |-> $past(prog_req_i && prog_ready_o && !prog_we_i))
    else $error("read data valid without a read");
  odd_miss_a: assert property (ana_req_i && ana_ready_o && ana_addr_i[0] |=> ana_miss_o && !mod_req_o)
    else $error("odd analog word not refused");
  direct_a: assert property (ana_req_i && ana_ready_o |=> ana_miss_o ^ mod_req_o)
    else $error("analog access neither missed nor forwarded");
  mod_hold_a: assert property (mod_req_o && !mod_ack_i |=> mod_req_o && $stable(mod_idx_o) && $stable(mod_chan_o))
    else $error("module request changed before acknowledge");
  ana_done_a: assert property (mod_req_o && mod_ack_i |=> ana_rvalid_o && !mod_req_o)
    else $error("analog access not closed after acknowledge");

  // Main scenarios reached
  cover property (upd_done_o);
  cover property (mod_req_o && mod_ack_i);
  cover property (ana_miss_o);
endmodule

bind ica_allocator ica_allocator_sva u_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .map_valid_o(map_valid_o), .upd_start_i(upd_start_i), .upd_busy_o(upd_busy_o),
  .upd_done_o(upd_done_o), .prog_req_i(prog_req_i), .prog_we_i(prog_we_i),
  .prog_ready_o(prog_ready_o), .prog_rvalid_o(prog_rvalid_o), .ana_req_i(ana_req_i),
  .ana_ready_o(ana_ready_o), .ana_addr_i(ana_addr_i), .ana_miss_o(ana_miss_o),
  .ana_rvalid_o(ana_rvalid_o), .mod_req_o(mod_req_o), .mod_idx_o(mod_idx_o),
  .mod_chan_o(mod_chan_o), .mod_ack_i(mod_ack_i));

// File: verification/ica_chain_model.sv
// Behavioural chain of digital and analog expansion modules
`timescale 1ns/100ps
module ica_chain_model (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Descriptor lookup
  input wire [2:0] desc_idx_i,
  output wire desc_present_o,
  output wire [4:0] desc_din_pts_o,
  output wire [4:0] desc_dout_pts_o,
  output wire [4:0] desc_ain_pts_o,
  output wire [4:0] desc_aout_pts_o,
  // Field input bytes
  input wire [4:0] fld_addr_i,
  output wire [7:0] fld_data_o,
  // Analog module access
  input wire mod_req_i,
  input wire mod_we_i,
  input wire mod_out_i,
  input wire [2:0] mod_idx_i,
  input wire [4:0] mod_chan_i,
  input wire [15:0] mod_wdata_i,
  output reg mod_ack_o,
  output wire [15:0] mod_rdata_o,
  output reg [7:0] last_dst_o,
  output reg [15:0] last_wd_o
);
  reg [20:0] desc;
  reg slow;
  reg [1:0] wait_cnt;
  wire [15:0] rd = {7'h50, mod_out_i, mod_idx_i, mod_chan_i};

  // Chain: 4in/4out, 8in, 3ai/1aq, 8out, 3ai/1aq, then empty slots
  always @* begin
    case (desc_idx_i)
      3'h0: desc = {1'b1, 5'h04, 5'h04, 5'h00, 5'h00};
      3'h1: desc = {1'b1, 5'h08, 5'h00, 5'h00, 5'h00};
      3'h2: desc = {1'b1, 5'h00, 5'h00, 5'h03, 5'h01};
      3'h3: desc = {1'b1, 5'h00, 5'h08, 5'h00, 5'h00};
      3'h4: desc = {1'b1, 5'h00, 5'h00, 5'h03, 5'h01};
      default: desc = 21'h000000;
    endcase
  end
  assign {desc_present_o, desc_din_pts_o, desc_dout_pts_o, desc_ain_pts_o, desc_aout_pts_o} = desc;
  // Field bytes carry ones in spare positions so masking shows
  assign fld_data_o = 8'hFF ^ {3'h0, fld_addr_i};
  // Data is only meaningful with acknowledge; otherwise the inverse is shown
  assign mod_rdata_o = mod_ack_o ? rd : ~rd;

  // Answers alternate prompt and slow so the held request is exercised
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mod_ack_o <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 2'h0;
      last_dst_o <= 8'h00;
      last_wd_o <= 16'h0000;
    end else if (mod_ack_o) begin
      mod_ack_o <= 1'b0;
      slow <= ~slow;
    end else if (mod_req_i) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        mod_ack_o <= 1'b1;
        wait_cnt <= 2'h0;
        last_dst_o <= {mod_idx_i, mod_chan_i};
        if (mod_we_i) begin
          last_wd_o <= mod_wdata_i;
        end
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

// File: verification/tb_ica_allocator.sv
// Self-checking bench for the I/O chain address allocator
`timescale 1ns/100ps
module tb_ica_allocator;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [2:0] qry_idx_i = 3'h0;
  reg upd_start_i = 1'b0;
  reg prog_req_i = 1'b0;
  reg prog_we_i = 1'b0;
  reg prog_out_i = 1'b0;
  reg [4:0] prog_addr_i = 5'h00;
  reg [7:0] prog_wdata_i = 8'h00;
  reg ana_req_i = 1'b0;
  reg ana_we_i = 1'b0;
  reg ana_out_i = 1'b0;
  reg [7:0] ana_addr_i = 8'h00;
  reg [15:0] ana_wdata_i = 16'h0000;
  wire [2:0] desc_idx_o, mod_idx_o;
  wire desc_present_i, map_valid_o, cfg_err_o, qry_valid_o, upd_busy_o, upd_done_o;
  wire [4:0] desc_din_pts_i, desc_dout_pts_i, desc_ain_pts_i, desc_aout_pts_i;
  wire [5:0] in_bytes_o, out_bytes_o, qry_din_base_o, qry_dout_base_o;
  wire [7:0] qry_ain_word_o, qry_aout_word_o, fld_data_i, prog_rdata_o, last_dst;
  wire [4:0] fld_addr_o, mod_chan_o;
  wire prog_ready_o, prog_rvalid_o, ana_ready_o, ana_miss_o, ana_rvalid_o;
  wire mod_req_o, mod_we_o, mod_out_o, mod_ack_i;
  wire [15:0] ana_rdata_o, mod_wdata_o, mod_rdata_i, last_wd;
  integer miscompares = 0;
  integer n_checks = 0;
  integer cycles = 0;
  integer i;
  integer k;
  reg [39:0] rows [0:5];

  ica_allocator DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .desc_idx_o(desc_idx_o), .desc_present_i(desc_present_i), .desc_din_pts_i(desc_din_pts_i),
    .desc_dout_pts_i(desc_dout_pts_i), .desc_ain_pts_i(desc_ain_pts_i),
    .desc_aout_pts_i(desc_aout_pts_i), .map_valid_o(map_valid_o), .cfg_err_o(cfg_err_o),
    .in_bytes_o(in_bytes_o), .out_bytes_o(out_bytes_o), .qry_idx_i(qry_idx_i),
    .qry_valid_o(qry_valid_o), .qry_din_base_o(qry_din_base_o), .qry_dout_base_o(qry_dout_base_o),
    .qry_ain_word_o(qry_ain_word_o), .qry_aout_word_o(qry_aout_word_o), .upd_start_i(upd_start_i),
    .upd_busy_o(upd_busy_o), .upd_done_o(upd_done_o), .fld_addr_o(fld_addr_o),
    .fld_data_i(fld_data_i), .prog_req_i(prog_req_i), .prog_we_i(prog_we_i),
    .prog_out_i(prog_out_i), .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i),
    .prog_ready_o(prog_ready_o), .prog_rvalid_o(prog_rvalid_o), .prog_rdata_o(prog_rdata_o),
    .ana_req_i(ana_req_i), .ana_we_i(ana_we_i), .ana_out_i(ana_out_i), .ana_addr_i(ana_addr_i),
    .ana_wdata_i(ana_wdata_i), .ana_ready_o(ana_ready_o), .ana_miss_o(ana_miss_o),
    .ana_rvalid_o(ana_rvalid_o), .ana_rdata_o(ana_rdata_o), .mod_req_o(mod_req_o),
    .mod_we_o(mod_we_o), .mod_out_o(mod_out_o), .mod_idx_o(mod_idx_o), .mod_chan_o(mod_chan_o),
    .mod_wdata_o(mod_wdata_o), .mod_ack_i(mod_ack_i), .mod_rdata_i(mod_rdata_i));

  ica_chain_model u_chain (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .desc_idx_i(desc_idx_o),
    .desc_present_o(desc_present_i), .desc_din_pts_o(desc_din_pts_i),
    .desc_dout_pts_o(desc_dout_pts_i), .desc_ain_pts_o(desc_ain_pts_i),
    .desc_aout_pts_o(desc_aout_pts_i), .fld_addr_i(fld_addr_o), .fld_data_o(fld_data_i),
    .mod_req_i(mod_req_o), .mod_we_i(mod_we_o), .mod_out_i(mod_out_o), .mod_idx_i(mod_idx_o),
    .mod_chan_i(mod_chan_o), .mod_wdata_i(mod_wdata_o), .mod_ack_o(mod_ack_i),
    .mod_rdata_o(mod_rdata_i), .last_dst_o(last_dst), .last_wd_o(last_wd));

  // 100 MHz clock and a hang guard well above the expected run
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask

  // Image access: request held until taken, read data looked at one cycle later
  task prog(input we, input out, input [4:0] addr, input [7:0] wd, input [7:0] exp);
    begin
      @(negedge core_clk_i);
      {prog_req_i, prog_we_i, prog_out_i, prog_addr_i, prog_wdata_i} = {1'b1, we, out, addr, wd};
      for (i = 0; i < 100 && prog_ready_o !== 1'b1; i = i + 1) @(negedge core_clk_i);
      @(negedge core_clk_i);
      prog_req_i = 1'b0;
      if (!we) chk(prog_rdata_o, exp);
      if (!we) chk(prog_rvalid_o, 1);
    end
  endtask

  // Analog access: dst is module index and channel the access must reach
  task ana(input we, input out, input [7:0] addr, input [15:0] wd, input hit, input [7:0] dst);
    begin
      @(negedge core_clk_i);
      {ana_req_i, ana_we_i, ana_out_i, ana_addr_i, ana_wdata_i} = {1'b1, we, out, addr, wd};
      for (i = 0; i < 100 && ana_ready_o !== 1'b1; i = i + 1) @(negedge core_clk_i);
      @(negedge core_clk_i);
      ana_req_i = 1'b0;
      for (i = 0; i < 50 && ana_miss_o !== 1'b1 && ana_rvalid_o !== 1'b1; i = i + 1)
        @(negedge core_clk_i);
      chk({ana_miss_o, ana_rvalid_o}, {!hit, hit});
      if (hit) chk({last_dst, ana_rdata_o}, {dst, 7'h50, out, dst});
      if (hit && we) chk(last_wd, wd);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Rows: valid, input base, output base, analog in word, analog out word; FF skips
    rows[0] = 40'h01_02_02_FF_FF;
    rows[1] = 40'h01_03_FF_FF_FF;
    rows[2] = 40'h01_FF_FF_00_00;
    rows[3] = 40'h01_FF_03_FF_FF;
    rows[4] = 40'h01_FF_FF_08_04;
    rows[5] = 40'h00_FF_FF_FF_FF;
    repeat (12) @(negedge core_clk_i);
    chk({map_valid_o, prog_ready_o, ana_ready_o}, 0);
    rst_n_i = 1'b1;
    for (k = 0; k < 200 && map_valid_o !== 1'b1; k = k + 1) @(negedge core_clk_i);
    chk({map_valid_o, cfg_err_o}, 2);
    chk({in_bytes_o, out_bytes_o}, {6'h04, 6'h04});
    for (k = 0; k < 6; k = k + 1) begin
      qry_idx_i = k[2:0];
      @(negedge core_clk_i);
      chk(qry_valid_o, rows[k][32]);
      if (rows[k][31:24] != 8'hFF) chk(qry_din_base_o, rows[k][31:24]);
      if (rows[k][23:16] != 8'hFF) chk(qry_dout_base_o, rows[k][23:16]);
      if (rows[k][15:8] != 8'hFF) chk(qry_ain_word_o, rows[k][15:8]);
      if (rows[k][7:0] != 8'hFF) chk(qry_aout_word_o, rows[k][7:0]);
    end
    prog(1, 0, 5'h02, 8'hFF, 8'h00);
    prog(1, 0, 5'h05, 8'h5A, 8'h00);
    prog(1, 1, 5'h01, 8'hA5, 8'h00);
    prog(1, 1, 5'h07, 8'h3C, 8'h00);
    @(negedge core_clk_i);
    upd_start_i = 1'b1;
    @(negedge core_clk_i);
    upd_start_i = 1'b0;
    for (k = 0; k < 40 && upd_done_o !== 1'b1; k = k + 1) @(negedge core_clk_i);
    chk(upd_done_o, 1);
    prog(0, 0, 5'h00, 8'h00, 8'hFF);
    prog(0, 0, 5'h01, 8'h00, 8'h3E);
    prog(0, 0, 5'h02, 8'h00, 8'h0D);
    prog(0, 0, 5'h03, 8'h00, 8'hFC);
    prog(0, 0, 5'h05, 8'h00, 8'h5A);
    prog(0, 1, 5'h01, 8'h00, 8'hA5);
    prog(0, 1, 5'h07, 8'h00, 8'h3C);
    ana(0, 0, 8'h00, 16'h0000, 1, 8'h40);
    ana(0, 0, 8'h02, 16'h0000, 1, 8'h41);
    ana(0, 0, 8'h04, 16'h0000, 1, 8'h42);
    ana(0, 0, 8'h06, 16'h0000, 0, 8'h00);
    ana(0, 0, 8'h03, 16'h0000, 0, 8'h00);
    ana(0, 0, 8'h08, 16'h0000, 1, 8'h80);
    ana(0, 0, 8'h0C, 16'h0000, 1, 8'h82);
    ana(0, 0, 8'h0E, 16'h0000, 0, 8'h00);
    ana(1, 1, 8'h00, 16'h1234, 1, 8'h40);
    ana(1, 1, 8'h02, 16'h5555, 0, 8'h00);
    ana(1, 1, 8'h04, 16'hBEEF, 1, 8'h80);
    ana(0, 1, 8'h06, 16'h0000, 0, 8'h00);
    // Reset in mid-run drops the map, and the walk rebuilds it
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    chk({map_valid_o, prog_ready_o, ana_ready_o, mod_req_o}, 0);
    rst_n_i = 1'b1;
    for (k = 0; k < 200 && map_valid_o !== 1'b1; k = k + 1) @(negedge core_clk_i);
    chk({map_valid_o, in_bytes_o, out_bytes_o}, {1'b1, 6'h04, 6'h04});
    print_verdict;
  end
endmodule
